/* File: rtl/pmta_pkg.sv */
package pmta_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int PMTA_PAGE_W = 8;
  localparam int PMTA_EA_W = 16;
  localparam int PMTA_ADDR_W = 24;
  localparam int PMTA_WORD_W = 24;
  localparam int PMTA_ROW_WORDS = 64;
  localparam int PMTA_PAGE_WORDS = 512;
  localparam int PMTA_ROW_IDX_W = 6;
  localparam int PMTA_LOW_LSB = 0;
  localparam int PMTA_HIGH_LSB = 16;
  localparam logic [7:0] PMTA_PHANTOM = 8'h00;
  localparam logic [7:0] PMTA_KEY1 = 8'h55;
  localparam logic [7:0] PMTA_KEY2 = 8'hAA;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PMTA_RD_LOW,
    PMTA_RD_HIGH,
    PMTA_WR_LOW,
    PMTA_WR_HIGH
  } pmta_op_t;

  typedef struct packed {
    logic valid;
    pmta_op_t op;
    logic byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
  } pmta_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } pmta_rsp_t;

  typedef struct packed {
    logic valid;
    logic [PMTA_ROW_IDX_W-1:0] idx;
    logic [2:0] lane_we;
    logic [PMTA_WORD_W-1:0] data;
  } pmta_buf_wr_t;

  typedef enum logic [1:0] {
    PMTA_K_IDLE,
    PMTA_K_GOT1,
    PMTA_K_ARMED
  } pmta_key_st_t;

endpackage

/* File: rtl/pmta_holding_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module pmta_holding_buf
  import pmta_pkg::*;
#(
  parameter int DEPTH = PMTA_ROW_WORDS,
  parameter int IDX_W = PMTA_ROW_IDX_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Table write side
  input wire pmta_pkg::pmta_buf_wr_t wr,
  input wire logic hold,
  // Programming engine read side
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [PMTA_WORD_W-1:0] rd_data
);
  import pmta_pkg::*;

  // Write lanes are bytes 0,1,2 of each word; no data address reaches here
  logic [PMTA_WORD_W-1:0] mem [DEPTH];

  // Loads are frozen while a cycle consumes the row
  always_ff @(posedge clock) begin
    if (!rst && wr.valid && !hold) begin
      for (int b = 0; b < 3; b++) begin
        if (wr.lane_we[b]) begin
          mem[wr.idx][b*8 +: 8] <= wr.data[b*8 +: 8];
        end
      end
    end
  end

  assign rd_data = mem[rd_idx];
endmodule
`default_nettype wire

/* File: rtl/pmta_key_unlock.sv */
`timescale 1ns/100ps
`default_nettype none
module pmta_key_unlock
  import pmta_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Key writes
  input wire logic key_we,
  input wire logic [7:0] key_data,
  // Start request and acceptance
  input wire logic start_req,
  output logic start_ok
);
  import pmta_pkg::*;

  typedef struct packed {
    pmta_key_st_t st;
  } pmta_key_state_t;

  pmta_key_state_t st_ff;
  pmta_key_state_t nxt_st;

  // Any other key write, or a start, breaks the sequence
  always_comb begin
    nxt_st = st_ff;
    start_ok = 1'b0;
    case (st_ff.st)
      PMTA_K_IDLE: begin
        if (key_we && key_data == PMTA_KEY1) begin
          nxt_st.st = PMTA_K_GOT1;
        end
      end
      PMTA_K_GOT1: begin
        if (key_we) begin
          nxt_st.st = (key_data == PMTA_KEY2) ? PMTA_K_ARMED : PMTA_K_IDLE;
        end else if (start_req) begin
          nxt_st.st = PMTA_K_IDLE;
        end
      end
      PMTA_K_ARMED: begin
        if (start_req) begin
          start_ok = 1'b1;
          nxt_st.st = PMTA_K_IDLE;
        end else if (key_we) begin
          nxt_st.st = (key_data == PMTA_KEY1) ? PMTA_K_GOT1 : PMTA_K_IDLE;
        end
      end
      default: nxt_st.st = PMTA_K_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '{st: PMTA_K_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pmta_table_access.sv */
`timescale 1ns/100ps
`default_nettype none
module pmta_table_access
  import pmta_pkg::*;
#(
  parameter int ROW_WORDS = PMTA_ROW_WORDS,
  parameter int ROW_IDX_W = PMTA_ROW_IDX_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Page select register write
  input wire logic page_we,
  input wire logic [PMTA_PAGE_W-1:0] page_wdata,
  // Table operation from the core
  input wire pmta_pkg::pmta_req_t req,
  output pmta_pkg::pmta_rsp_t rsp,
  // Program memory read port, combinational data
  output logic [PMTA_ADDR_W-2:0] pm_rd_addr,
  input wire logic [PMTA_WORD_W-1:0] pm_rd_data,
  // Unlock key and programming start
  input wire logic key_we,
  input wire logic [7:0] key_wdata,
  input wire logic start_req,
  // Programming engine
  output logic prog_start,
  output logic [PMTA_ADDR_W-2:0] prog_row_addr,
  input wire logic prog_done,
  input wire logic [ROW_IDX_W-1:0] prog_idx,
  output logic [PMTA_WORD_W-1:0] prog_data,
  // Status
  output logic prog_busy,
  output logic [PMTA_PAGE_W-1:0] page_sel
);
  import pmta_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [PMTA_PAGE_W-1:0] page;
    pmta_rsp_t rsp;
    logic busy;
    logic start;
    logic [PMTA_ADDR_W-2:0] last_row;
    logic [PMTA_ADDR_W-2:0] row;
  } pmta_state_t;

  pmta_state_t st_ff;
  pmta_state_t nxt_st;

  logic [PMTA_ADDR_W-1:0] full_addr;
  logic [PMTA_ADDR_W-2:0] word_addr;
  logic start_ok;
  pmta_buf_wr_t buf_wr;
  logic [15:0] half_rd;
  logic [7:0] sel_byte;

  // ****************************************
  // Address and read data
  // ****************************************
  assign full_addr = {st_ff.page, req.ea};
  assign word_addr = full_addr[PMTA_ADDR_W-1:1];
  assign pm_rd_addr = word_addr;

  always_comb begin
    half_rd = 16'h0000;
    if (req.op == PMTA_RD_HIGH) begin
      // Upper half of the high space does not exist
      half_rd = {PMTA_PHANTOM, pm_rd_data[PMTA_HIGH_LSB +: 8]};
    end else begin
      half_rd = pm_rd_data[PMTA_LOW_LSB +: 16];
    end
    sel_byte = req.ea[0] ? half_rd[15:8] : half_rd[7:0];
  end

  // ****************************************
  // Holding buffer write steering
  // ****************************************
  always_comb begin
    buf_wr = '0;
    buf_wr.idx = word_addr[ROW_IDX_W-1:0];
    buf_wr.valid = req.valid && !st_ff.busy &&
                   (req.op == PMTA_WR_LOW || req.op == PMTA_WR_HIGH);
    if (req.op == PMTA_WR_LOW) begin
      if (req.byte_mode) begin
        buf_wr.lane_we = req.ea[0] ? 3'h2 : 3'h1;
        buf_wr.data = {8'h00, req.wdata[7:0], req.wdata[7:0]};
      end else begin
        buf_wr.lane_we = 3'h3;
        buf_wr.data = {8'h00, req.wdata};
      end
    end else begin
      // Phantom lane never enabled, so its writes vanish
      if (req.byte_mode) begin
        buf_wr.lane_we = req.ea[0] ? 3'h0 : 3'h4;
      end else begin
        buf_wr.lane_we = 3'h4;
      end
      buf_wr.data = {req.wdata[7:0], 16'h0000};
    end
  end

  pmta_holding_buf #(
    .DEPTH(ROW_WORDS),
    .IDX_W(ROW_IDX_W)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .wr(buf_wr),
    .hold(st_ff.busy),
    .rd_idx(prog_idx),
    .rd_data(prog_data)
  );

  pmta_key_unlock u_key (
    .clock(clock),
    .rst(rst),
    .key_we(key_we),
    .key_data(key_wdata),
    .start_req(start_req),
    .start_ok(start_ok)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.rsp.valid = 1'b0;
    if (page_we) begin
      nxt_st.page = page_wdata;
    end
    if (req.valid && (req.op == PMTA_RD_LOW || req.op == PMTA_RD_HIGH)) begin
      nxt_st.rsp.valid = 1'b1;
      nxt_st.rsp.rdata = req.byte_mode ? {8'h00, sel_byte} : half_rd;
    end
    if (req.valid && !st_ff.busy &&
        (req.op == PMTA_WR_LOW || req.op == PMTA_WR_HIGH)) begin
      nxt_st.last_row = word_addr;
    end
    // Only the unlocked start begins a cycle, never a buffer load
    if (start_ok && !st_ff.busy) begin
      nxt_st.start = 1'b1;
      nxt_st.busy = 1'b1;
      nxt_st.row = {st_ff.last_row[PMTA_ADDR_W-2:ROW_IDX_W],
                    {ROW_IDX_W{1'b0}}};
    end else if (st_ff.busy && prog_done) begin
      nxt_st.busy = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp = st_ff.rsp;
  assign prog_start = st_ff.start;
  assign prog_row_addr = st_ff.row;
  assign prog_busy = st_ff.busy;
  assign page_sel = st_ff.page;
endmodule
`default_nettype wire

/* File: tb/pmta_table_access_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pmta_table_access_assertions
  import pmta_pkg::*;
(
  // Watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic page_we,
  input wire logic [7:0] page_wdata,
  input wire pmta_pkg::pmta_req_t req,
  input wire pmta_pkg::pmta_rsp_t rsp,
  input wire logic [22:0] pm_rd_addr,
  input wire logic [23:0] pm_rd_data,
  input wire logic start_req,
  input wire logic prog_start,
  input wire logic prog_done,
  input wire logic prog_busy,
  input wire logic [7:0] page_sel
);
  import pmta_pkg::*;

  // ****
  // Checks
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic rd = req.valid && !req.op[1];
  wire logic rlo = rd && !req.op[0];
  wire logic rhi = rd && req.op[0];
  wire logic bm = req.byte_mode;
  chk_rd_answer: assert property (rd |=> rsp.valid)
    else $error("read not answered");
  chk_wr_silent: assert property (req.valid && req.op[1] |=> !rsp.valid)
    else $error("write answered");
  chk_rd_address: assert property (
    req.valid |-> pm_rd_addr == {page_sel, req.ea[15:1]})
    else $error("bad read address");
  chk_low_word: assert property (
    rlo && !bm |=> rsp.rdata == $past(pm_rd_data[15:0]))
    else $error("bad low word");
  chk_high_word: assert property (
    rhi && !bm |=> rsp.rdata == {8'h00, $past(pm_rd_data[23:16])})
    else $error("bad high word");
  chk_phantom_read: assert property (
    rhi && bm && req.ea[0] |=> rsp.rdata == 16'h0000)
    else $error("phantom not zero");
  chk_byte_pick: assert property (
    rlo && bm && req.ea[0] |=> rsp.rdata == {8'h00, $past(pm_rd_data[15:8])})
    else $error("bad byte pick");
  chk_start_cause: assert property (
    prog_start |-> $past(start_req) && !$past(prog_busy) && prog_busy)
    else $error("start without request");
  chk_busy_clear: assert property (prog_busy && prog_done |=> !prog_busy)
    else $error("busy stuck");
  chk_page_load: assert property (page_we |=> page_sel == $past(page_wdata))
    else $error("page not loaded");
  cover property (prog_start);
  cover property (rhi && bm && req.ea[0]);
  cover property (prog_busy && prog_done);
endmodule
`default_nettype wire

/* File: tb/pmta_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmta_prog_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Memory read
  input wire logic [22:0] pm_rd_addr,
  output logic [23:0] pm_rd_data,
  // Programming engine
  input wire logic prog_start,
  input wire logic [5:0] peek_idx,
  output logic prog_done,
  output logic [5:0] prog_idx
);
  // ****
  // Memory and engine
  // ****
  logic [6:0] cnt_ff;
  assign pm_rd_data = {pm_rd_addr[7:0] ^ 8'h3C, pm_rd_addr[15:0]};
  // Walks all row entries while running, else lets the bench peek
  assign prog_idx = cnt_ff[6] ? cnt_ff[5:0] : peek_idx;
  assign prog_done = cnt_ff == 7'h7F;
  always_ff @(posedge clock) begin
    if (rst || prog_done) begin
      cnt_ff <= 7'h00;
    end else if (prog_start) begin
      cnt_ff <= 7'h40;
    end else if (cnt_ff[6]) begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_program_memory_table_access.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_program_memory_table_access;
  import pmta_pkg::*;
  logic clock = 0, rst = 1, page_we = 0, key_we = 0, start_req = 0;
  logic [7:0] page_wdata = 0, key_wdata = 0, page_sel;
  logic [5:0] peek_idx = 0, prog_idx;
  pmta_req_t req = '0;
  pmta_rsp_t rsp;
  logic [22:0] pm_rd_addr, prog_row_addr;
  logic [23:0] pm_rd_data, prog_data, w, lo;
  logic prog_start, prog_done, prog_busy;
  int err_total = 0, checks = 0, cyc = 0;
  pmta_table_access pmta_table_access_i (.clock(clock), .rst(rst),
    .page_we(page_we), .page_wdata(page_wdata), .req(req), .rsp(rsp),
    .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data), .key_we(key_we),
    .key_wdata(key_wdata), .start_req(start_req), .prog_start(prog_start),
    .prog_row_addr(prog_row_addr), .prog_done(prog_done),
    .prog_idx(prog_idx), .prog_data(prog_data), .prog_busy(prog_busy),
    .page_sel(page_sel));
  pmta_prog_model pmta_prog_model_i (.clock(clock), .rst(rst),
    .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data),
    .prog_start(prog_start), .peek_idx(peek_idx), .prog_done(prog_done),
    .prog_idx(prog_idx));
  // ****
  // Tasks
  // ****
  always #12.5 clock = ~clock;
  task automatic chk(input logic [23:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic op(input pmta_op_t o, input logic b, input logic [15:0] e, d);
    @(posedge clock);
    req <= '{1'b1, o, b, e, d};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic key(input logic [7:0] d);
    @(posedge clock);
    key_we <= 1'b1;
    key_wdata <= d;
    @(posedge clock);
    key_we <= 1'b0;
  endtask
  task automatic start(input logic exp);
    @(posedge clock);
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    #1 chk(prog_start, exp);
  endtask
  task automatic peek(input logic [5:0] i, input logic [23:0] exp);
    @(posedge clock);
    peek_idx <= i;
    #1 chk(prog_data, exp);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1 chk({rsp.valid, prog_start, prog_busy, page_sel}, 0);
    @(posedge clock);
    page_we <= 1'b1;
    page_wdata <= 8'h12;
    @(posedge clock);
    page_we <= 1'b0;
    #1 chk(page_sel, 8'h12);
    for (int i = 0; i < 8; i++) begin
      op(i[2] ? PMTA_RD_HIGH : PMTA_RD_LOW, i[1], 16'h3456 | i[0], 0);
      w = {8'h2B ^ 8'h3C, 16'h1A2B};
      lo = i[2] ? {8'h00, w[23:16]} : w[15:0];
      chk(rsp.valid, 1);
      chk(rsp.rdata, !i[1] ? lo : (i[0] ? lo[15:8] : lo[7:0]));
    end
    // Three bytes of one word: high, low, then middle with increment
    op(PMTA_RD_HIGH, 1, 16'h3456, 0);
    chk(rsp.rdata, 24'h000017);
    op(PMTA_RD_LOW, 1, 16'h3456, 0);
    chk(rsp.rdata, 24'h00002B);
    op(PMTA_RD_LOW, 1, 16'h3457, 0);
    chk(rsp.rdata, 24'h00001A);
    $display("reads done");
    op(PMTA_WR_LOW, 0, 16'h00E0, 16'hBEEF);
    op(PMTA_WR_HIGH, 0, 16'h00E0, 16'hAB12);
    op(PMTA_WR_HIGH, 1, 16'h00E2, 16'hFF34);
    op(PMTA_WR_LOW, 1, 16'h00E2, 16'hFF56);
    op(PMTA_WR_LOW, 1, 16'h00E3, 16'hFF78);
    op(PMTA_WR_HIGH, 1, 16'h00E3, 16'hFF99);
    peek(6'h30, 24'h12BEEF);
    peek(6'h31, 24'h347856);
    chk(prog_busy, 0);
    $display("writes done");
    start(0);
    key(8'h55);
    key(8'h12);
    key(8'hAA);
    start(0);
    key(8'h55);
    key(8'hAA);
    start(1);
    chk({prog_busy, prog_row_addr}, {1'b1, 23'h090040});
    op(PMTA_WR_LOW, 0, 16'h00E2, 16'h0000);
    // Programming must end before the next location is loaded
    for (int n = 0; n < 200 && prog_busy !== 1'b0; n++) begin
      @(posedge clock);
    end
    #1 chk(prog_busy, 0);
    peek(6'h31, 24'h347856);
    op(PMTA_WR_LOW, 0, 16'h00E2, 16'h0000);
    peek(6'h31, 24'h340000);
    start(0);
    $display("start done");
    end_of_test();
  end
endmodule
bind pmta_table_access pmta_table_access_assertions chk_i (
  .clock(clock), .rst(rst), .page_we(page_we), .page_wdata(page_wdata),
  .req(req), .rsp(rsp), .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data),
  .start_req(start_req), .prog_start(prog_start), .prog_done(prog_done),
  .prog_busy(prog_busy), .page_sel(page_sel));
`default_nettype wire
